// file: crcs_pkg.sv
// Shared constants and types for the reset and configuration sequencer
package crcs_pkg;

   // System clock period
   localparam longint MCLK_PS    = 64'd4000;
   localparam longint PS_PER_US  = 64'd1000000;
   localparam longint PS_PER_MS  = 64'd1000000000;

   // Power-good to reset release window, and reset pulse width
   localparam longint RST_MIN_MS  = 64'd1;
   localparam longint RST_MAX_MS  = 64'd10;
   localparam int     RST_MIN_CYC = int'((RST_MIN_MS * PS_PER_MS + MCLK_PS - 1) / MCLK_PS);
   localparam int     RST_MAX_CYC = int'((RST_MAX_MS * PS_PER_MS) / MCLK_PS);

   // Power-good low time and side-band pulse width, in bus clocks
   localparam logic [31:0] PG_OFF_MIN_CYC = 32'ha;
   localparam logic [1:0]  SB_MIN_CYC     = 2'h2;

   // Configuration strap setup and hold around reset release, in bus clocks
   localparam int          CFG_SETUP_CYC    = 4;
   localparam int          CFG_HOLD_MIN_CYC = 2;
   localparam int          CFG_HOLD_MAX_CYC = 20;
   localparam logic [31:0] CFG_HOLD_CYC     = 32'h4;

   // Throttle output least assertion time
   localparam longint THROT_MIN_US  = 64'd500;
   localparam int     THROT_MIN_CYC = int'((THROT_MIN_US * PS_PER_US + MCLK_PS - 1) / MCLK_PS);

   // Longest time from thermal shutdown to supply removal, in seconds
   localparam real    TRIP_MAX_S = 0.5;

   // Test clock: least period, derived half period, test reset length
   localparam longint     TCK_MIN_PS   = 64'd60000;
   localparam logic [3:0] TCK_HALF_CYC =
      4'((TCK_MIN_PS + 2 * MCLK_PS - 1) / (2 * MCLK_PS));
   localparam logic [1:0] TRST_MIN_TCK = 2'h2;
   localparam logic [2:0] TAP_RESET_TMS = 3'h5;

   // Identity word loaded into the test chain; value is arbitrary
   localparam logic [31:0] TAP_IDENT = 32'h0000_0a5b;

   // Strap widths: address 31..3, then bus request, soft init, management
   localparam int CFG_ADDR_W = 29;
   localparam int CFG_W      = CFG_ADDR_W + 3;

   // Platform power sequence states
   typedef enum logic [2:0] {
      PS_OFF  = 3'b000,
      PS_PWR  = 3'b001,
      PS_HOLD = 3'b011,
      PS_RUN  = 3'b010,
      PS_TRIP = 3'b110
   } crcs_pseq_t;

   // Platform test port states
   typedef enum logic [1:0] {
      TS_IDLE = 2'b00,
      TS_LOW  = 2'b01,
      TS_HIGH = 2'b11,
      TS_END  = 2'b10
   } crcs_tseq_t;

   // Device throttle states
   typedef enum logic [1:0] {
      TH_IDLE  = 2'b00,
      TH_ENTER = 2'b01,
      TH_HOLD  = 2'b11,
      TH_EXIT  = 2'b10
   } crcs_thr_t;

endpackage

// file: crcs_if.sv
// Pin-level link between the processor end and the platform end
`timescale 1ns/1ps
interface crcs_if;
   import crcs_pkg::*;

   // Power and reset
   logic                  supply_ok_in;
   logic                  reset_n;
   // Reset configuration straps, active low
   logic [CFG_ADDR_W-1:0] cfg_addr_n;
   logic                  bus_request0_n;
   logic                  soft_init_n;
   logic                  mgmt_interrupt_n;
   // Thermal outputs
   logic                  thermal_throttle_n;
   logic                  thermal_shutdown_n;
   // Test port
   logic                  tck;
   logic                  tms;
   logic                  tdi;
   logic                  trst_n;
   logic                  tdo;

   modport dev (
      input  supply_ok_in, reset_n, cfg_addr_n, bus_request0_n, soft_init_n,
      input  mgmt_interrupt_n, tck, tms, tdi, trst_n,
      output thermal_throttle_n, thermal_shutdown_n, tdo
   );

   modport plat (
      output supply_ok_in, reset_n, cfg_addr_n, bus_request0_n, soft_init_n,
      output mgmt_interrupt_n, tck, tms, tdi, trst_n,
      input  thermal_throttle_n, thermal_shutdown_n, tdo
   );

endinterface

// file: crcs_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module crcs_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // Pins and their synchronised copy
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;

   // First stage feeds only the second
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         meta_ff <= INIT;
         q       <= INIT;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// file: crcs_dev.sv
// Processor end: strap capture, side-band inputs, thermal outputs, test port
`timescale 1ns/1ps
module crcs_dev #(
   parameter int unsigned THROT_CYC = crcs_pkg::THROT_MIN_CYC
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    resetn,
   // Pins
   crcs_if.dev                          pins,
   // Core status
   output logic                         core_rst_n,
   output logic                         cfg_valid,
   output logic [crcs_pkg::CFG_W-1:0]   cfg_word,
   output logic                         init_evt,
   output logic                         mgmt_evt,
   // Thermal
   input  wire logic                    temp_hot,
   input  wire logic                    temp_trip,
   input  wire logic                    insn_busy,
   output logic                         clk_mod_on
);
   import crcs_pkg::*;

   localparam int SW = CFG_ADDR_W + 9;

   typedef struct packed {
      logic             run_prev;
      logic             core_rst_n;
      logic             cfg_valid;
      logic [CFG_W-1:0] cfg;
      logic             init_prev;
      logic             mgmt_prev;
      logic             init_evt;
      logic             mgmt_evt;
      crcs_thr_t        th_st;
      logic [31:0]      th_cnt;
      logic             throttle_n;
      logic             mod_on;
      logic             trip_n;
      logic             tck_prev;
      logic [2:0]       tms_cnt;
      logic [31:0]      sr;
      logic             tdo;
   } crcs_dev_st_t;

   crcs_dev_st_t st_ff;
   crcs_dev_st_t nxt_st;
   logic [SW-1:0] pin_s;
   logic          supply_s;
   logic          reset_s;
   logic [CFG_W-1:0] cfg_s;
   logic          tck_s;
   logic          tms_s;
   logic          tdi_s;
   logic          trst_s;
   logic          run;

   crcs_sync #(
      .W    (SW),
      .INIT ({2'h0, {CFG_W{1'b1}}, 4'h0})
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d      ({pins.supply_ok_in, pins.reset_n, pins.cfg_addr_n, pins.bus_request0_n,
                pins.soft_init_n, pins.mgmt_interrupt_n, pins.tck, pins.tms, pins.tdi,
                pins.trst_n}),
      .q      (pin_s)
   );

   // Split of synchronised pins
   assign {supply_s, reset_s, cfg_s, tck_s, tms_s, tdi_s, trst_s} = pin_s;
   assign run = supply_s & reset_s;

   // Next state
   always_comb begin
      nxt_st            = st_ff;
      nxt_st.run_prev   = run;
      nxt_st.core_rst_n = run;
      nxt_st.init_prev  = cfg_s[1];
      nxt_st.mgmt_prev  = cfg_s[0];
      nxt_st.tck_prev   = tck_s;
      if (!run) begin
         nxt_st.cfg_valid = 1'b0;
      end else if (!st_ff.run_prev) begin
         nxt_st.cfg       = ~cfg_s;
         nxt_st.cfg_valid = 1'b1;
      end
      // Falling side-band edges after capture
      nxt_st.init_evt = st_ff.cfg_valid & st_ff.init_prev & ~cfg_s[1];
      nxt_st.mgmt_evt = st_ff.cfg_valid & st_ff.mgmt_prev & ~cfg_s[0];
      if (!st_ff.throttle_n && st_ff.th_cnt != 32'hffff_ffff) begin
         nxt_st.th_cnt = st_ff.th_cnt + 32'h1;
      end
      unique case (st_ff.th_st)
         TH_IDLE: begin
            if (temp_hot) begin
               nxt_st.throttle_n = 1'b0;
               nxt_st.th_cnt     = 32'h0;
               nxt_st.th_st      = TH_ENTER;
            end
         end
         TH_ENTER: begin
            if (!insn_busy) begin
               nxt_st.mod_on = 1'b1;
               nxt_st.th_st  = TH_HOLD;
            end
         end
         TH_HOLD: begin
            if (!temp_hot && st_ff.th_cnt >= 32'(THROT_CYC)) begin
               nxt_st.mod_on = 1'b0;
               nxt_st.th_st  = TH_EXIT;
            end
         end
         TH_EXIT: begin
            if (!insn_busy) begin
               nxt_st.throttle_n = 1'b1;
               nxt_st.th_st      = TH_IDLE;
            end
         end
      endcase
      // Shutdown is sticky until reset
      if (temp_trip) begin
         nxt_st.trip_n = 1'b0;
      end
      if (!trst_s) begin
         nxt_st.sr      = TAP_IDENT;
         nxt_st.tms_cnt = 3'h0;
      end else if (tck_s && !st_ff.tck_prev) begin
         if (tms_s) begin
            if (st_ff.tms_cnt == TAP_RESET_TMS - 3'h1) begin
               nxt_st.sr      = TAP_IDENT;
               nxt_st.tms_cnt = 3'h0;
            end else begin
               nxt_st.tms_cnt = st_ff.tms_cnt + 3'h1;
            end
         end else begin
            nxt_st.sr      = {tdi_s, st_ff.sr[31:1]};
            nxt_st.tms_cnt = 3'h0;
         end
      end
      // launch on falling edge, also during test reset
      if (!tck_s && st_ff.tck_prev) begin
         nxt_st.tdo = st_ff.sr[0];
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_ff            <= '0;
         st_ff.init_prev  <= 1'b1;
         st_ff.mgmt_prev  <= 1'b1;
         st_ff.th_st      <= TH_IDLE;
         st_ff.throttle_n <= 1'b1;
         st_ff.trip_n     <= 1'b1;
         st_ff.sr         <= TAP_IDENT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign pins.thermal_throttle_n = st_ff.throttle_n;
   assign pins.thermal_shutdown_n = st_ff.trip_n;
   assign pins.tdo                = st_ff.tdo;
   assign core_rst_n              = st_ff.core_rst_n;
   assign cfg_valid               = st_ff.cfg_valid;
   assign cfg_word                = st_ff.cfg;
   assign init_evt                = st_ff.init_evt;
   assign mgmt_evt                = st_ff.mgmt_evt;
   assign clk_mod_on              = st_ff.mod_on;

endmodule

// file: crcs_plat.sv
// Platform end: power-good, reset, straps, side-band pulses and test port
`timescale 1ns/1ps
module crcs_plat #(
   parameter int unsigned RST_CYC = crcs_pkg::RST_MIN_CYC
) (
   // Clock and reset
   input  wire logic                         mclk,
   input  wire logic                         resetn,
   // Pins
   crcs_if.plat                              pins,
   // Power control
   input  wire logic                         power_req,
   output logic                              vcore_en,
   output logic                              sys_ready,
   output logic                              tripped,
   output logic                              hot_seen,
   // Strap values, one means asserted
   input  wire logic [crcs_pkg::CFG_ADDR_W-1:0] strap_addr,
   input  wire logic                         strap_breq,
   input  wire logic                         strap_init,
   input  wire logic                         strap_mgmt,
   // Side-band requests, one-cycle pulses
   input  wire logic                         init_req,
   input  wire logic                         mgmt_req,
   // Test port requests
   input  wire logic                         tap_rst_req,
   input  wire logic                         tap_shift_req,
   input  wire logic                         tap_tms_in,
   input  wire logic                         tap_tdi_in,
   output logic                              tap_busy,
   output logic                              tap_done,
   output logic                              tap_tdo
);
   import crcs_pkg::*;

   typedef struct packed {
      crcs_pseq_t            st;
      logic [31:0]           cnt;
      logic                  vcore_en;
      logic                  supply_ok;
      logic                  rst_n;
      logic [CFG_ADDR_W-1:0] addr_n;
      logic                  breq_n;
      logic                  init_n;
      logic                  mgmt_n;
      logic [1:0]            init_cnt;
      logic [1:0]            mgmt_cnt;
      logic                  tripped;
      logic                  ready;
      logic                  hot;
      crcs_tseq_t            tst;
      logic [3:0]            half;
      logic [1:0]            per;
      logic                  tap_rst;
      logic                  tck;
      logic                  tms;
      logic                  tdi;
      logic                  trst_n;
      logic                  done;
      logic                  busy;
      logic                  tdo;
   } crcs_plat_st_t;

   crcs_plat_st_t st_ff;
   crcs_plat_st_t nxt_st;
   logic          throttle_s;
   logic          shutdown_s;
   logic          tdo_s;
   logic          drive_straps;

   // Processor outputs synchronised
   crcs_sync #(
      .W    (3),
      .INIT (3'h6)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d      ({pins.thermal_throttle_n, pins.thermal_shutdown_n, pins.tdo}),
      .q      ({throttle_s, shutdown_s, tdo_s})
   );

   // Stretch count for a side-band pulse
   function automatic logic [1:0] stretch(input logic req, input logic [1:0] cnt);
      if (req) begin
         stretch = SB_MIN_CYC;
      end else if (cnt != 2'h0) begin
         stretch = cnt - 2'h1;
      end else begin
         stretch = 2'h0;
      end
   endfunction

   // Power sequence next state
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.hot      = ~throttle_s;
      nxt_st.done     = 1'b0;
      nxt_st.init_cnt = 2'h0;
      nxt_st.mgmt_cnt = 2'h0;
      drive_straps    = 1'b0;
      if (st_ff.cnt != 32'hffff_ffff) begin
         nxt_st.cnt = st_ff.cnt + 32'h1;
      end
      unique case (st_ff.st)
         PS_OFF: begin
            if (power_req && st_ff.cnt >= PG_OFF_MIN_CYC - 32'h1) begin
               nxt_st.st        = PS_PWR;
               nxt_st.cnt       = 32'h0;
               nxt_st.vcore_en  = 1'b1;
               nxt_st.supply_ok = 1'b1;
            end
         end
         PS_PWR: begin
            drive_straps = 1'b1;
            if (!power_req) begin
               nxt_st.st = PS_OFF;
            end else if (st_ff.cnt == 32'(RST_CYC - 1)) begin
               nxt_st.rst_n = 1'b1;
               nxt_st.st    = PS_HOLD;
               nxt_st.cnt   = 32'h0;
            end
         end
         PS_HOLD: begin
            drive_straps = 1'b1;
            if (!power_req) begin
               nxt_st.st = PS_OFF;
            end else if (st_ff.cnt == CFG_HOLD_CYC - 32'h1) begin
               nxt_st.st    = PS_RUN;
               nxt_st.ready = 1'b1;
            end
         end
         PS_RUN: begin
            nxt_st.init_cnt = stretch(init_req, st_ff.init_cnt);
            nxt_st.mgmt_cnt = stretch(mgmt_req, st_ff.mgmt_cnt);
            if (!power_req) begin
               nxt_st.st = PS_OFF;
            end
         end
         // Supply stays off until power is withdrawn
         PS_TRIP: begin
            if (!power_req) begin
               nxt_st.st  = PS_OFF;
               nxt_st.cnt = 32'h0;
            end
         end
         default: begin
            nxt_st.st = PS_OFF;
         end
      endcase
      if (!shutdown_s && st_ff.st != PS_OFF && st_ff.st != PS_TRIP) begin
         nxt_st.st      = PS_TRIP;
         nxt_st.tripped = 1'b1;
      end
      if (nxt_st.st == PS_OFF || nxt_st.st == PS_TRIP) begin
         if (st_ff.st != PS_OFF && st_ff.st != PS_TRIP) begin
            nxt_st.cnt = 32'h0;
         end
         nxt_st.vcore_en  = 1'b0;
         nxt_st.supply_ok = 1'b0;
         nxt_st.rst_n     = 1'b0;
         nxt_st.ready     = 1'b0;
      end
      if (nxt_st.st == PS_PWR) begin
         nxt_st.tripped = 1'b0;
      end
      if (drive_straps && nxt_st.st != PS_RUN && nxt_st.st != PS_OFF) begin
         nxt_st.addr_n = ~strap_addr;
         nxt_st.breq_n = ~strap_breq;
         nxt_st.init_n = ~strap_init;
         nxt_st.mgmt_n = ~strap_mgmt;
      end else begin
         nxt_st.addr_n = '1;
         nxt_st.breq_n = 1'b1;
         nxt_st.init_n = nxt_st.init_cnt == 2'h0;
         nxt_st.mgmt_n = nxt_st.mgmt_cnt == 2'h0;
      end

      // Test port engine
      unique case (st_ff.tst)
         TS_IDLE: begin
            if (tap_rst_req || tap_shift_req) begin
               nxt_st.tst     = TS_LOW;
               nxt_st.half    = 4'h0;
               nxt_st.tap_rst = tap_rst_req;
               nxt_st.per     = tap_rst_req ? TRST_MIN_TCK : 2'h1;
               nxt_st.tms     = tap_rst_req ? 1'b1 : tap_tms_in;
               nxt_st.tdi     = tap_tdi_in;
               nxt_st.trst_n  = ~tap_rst_req;
            end
         end
         TS_LOW: begin
            nxt_st.half = st_ff.half + 4'h1;
            if (st_ff.half == TCK_HALF_CYC - 4'h1) begin
               nxt_st.half = 4'h0;
               nxt_st.tck  = 1'b1;
               nxt_st.tdo  = tdo_s;
               nxt_st.tst  = TS_HIGH;
            end
         end
         TS_HIGH: begin
            nxt_st.half = st_ff.half + 4'h1;
            if (st_ff.half == TCK_HALF_CYC - 4'h1) begin
               nxt_st.half = 4'h0;
               nxt_st.tck  = 1'b0;
               nxt_st.per  = st_ff.per - 2'h1;
               nxt_st.tst  = (st_ff.per == 2'h1) ? TS_END : TS_LOW;
            end
         end
         TS_END: begin
            nxt_st.trst_n = 1'b1;
            nxt_st.done   = 1'b1;
            nxt_st.tst    = TS_IDLE;
         end
      endcase
      // Busy flag registered with the state
      nxt_st.busy = nxt_st.tst != TS_IDLE;
   end

   // State register
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_ff        <= '0;
         st_ff.st     <= PS_OFF;
         st_ff.tst    <= TS_IDLE;
         st_ff.addr_n <= '1;
         st_ff.breq_n <= 1'b1;
         st_ff.init_n <= 1'b1;
         st_ff.mgmt_n <= 1'b1;
         st_ff.trst_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Pin outputs
   assign pins.supply_ok_in     = st_ff.supply_ok;
   assign pins.reset_n          = st_ff.rst_n;
   assign pins.cfg_addr_n       = st_ff.addr_n;
   assign pins.bus_request0_n   = st_ff.breq_n;
   assign pins.soft_init_n      = st_ff.init_n;
   assign pins.mgmt_interrupt_n = st_ff.mgmt_n;
   assign pins.tck              = st_ff.tck;
   assign pins.tms              = st_ff.tms;
   assign pins.tdi              = st_ff.tdi;
   assign pins.trst_n           = st_ff.trst_n;

   // User outputs
   assign vcore_en  = st_ff.vcore_en;
   assign sys_ready = st_ff.ready;
   assign tripped   = st_ff.tripped;
   assign hot_seen  = st_ff.hot;
   assign tap_busy  = st_ff.busy;
   assign tap_done  = st_ff.done;
   assign tap_tdo   = st_ff.tdo;

endmodule

// file: crcs_checker.sv
// Concurrent checks on the link between the processor end and the platform end
`timescale 1ns/1ps
module crcs_checker #(
   parameter int RST_CYC = 20,
   parameter int THR_CYC = 16
) (
   // Clock and reset
   input wire logic                              mclk,
   input wire logic                              resetn,
   // Link pins
   input wire logic                              supply_ok_in,
   input wire logic                              reset_n,
   input wire logic [crcs_pkg::CFG_ADDR_W-1:0]   cfg_addr_n,
   input wire logic                              bus_request0_n,
   input wire logic                              soft_init_n,
   input wire logic                              mgmt_interrupt_n,
   input wire logic                              thermal_throttle_n,
   input wire logic                              thermal_shutdown_n,
   input wire logic                              tck,
   input wire logic                              tms,
   input wire logic                              trst_n
);
   import crcs_pkg::*;
   logic [CFG_W-1:0] straps;
   int               rst_cnt_ff;
   int               thr_cnt_ff;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Strap pins as one word
   assign straps = {cfg_addr_n, bus_request0_n, soft_init_n, mgmt_interrupt_n};
   // Reset wait and throttle low counters
   always_ff @(posedge mclk) begin
      rst_cnt_ff <= (!resetn || !supply_ok_in) ? 0 : rst_cnt_ff + (reset_n ? 0 : 1);
      thr_cnt_ff <= (!resetn || thermal_throttle_n) ? 0 : thr_cnt_ff + 1;
   end
   a_pg_off_min: assert property (
      $fell(supply_ok_in) |-> !supply_ok_in[*8] ##1 !supply_ok_in[*2])
      else $error("power-good low time too short");
   a_rst_window: assert property (
      $rose(reset_n) |-> supply_ok_in && rst_cnt_ff >= RST_CYC && rst_cnt_ff <= 10 * RST_CYC)
      else $error("reset release outside window");
   a_strap_setup: assert property (
      $rose(reset_n) |-> straps == $past(straps, 1) && straps == $past(straps, 2)
         && straps == $past(straps, 3) && straps == $past(straps, 4))
      else $error("straps moved before reset release");
   a_strap_hold: assert property (
      $rose(reset_n) |-> $stable(straps)[*3] ##[0:18] (&straps))
      else $error("strap hold after release wrong");
   a_init_width: assert property (
      $fell(soft_init_n) |-> !soft_init_n[*2])
      else $error("init pulse too short");
   a_mgmt_width: assert property (
      $fell(mgmt_interrupt_n) |-> !mgmt_interrupt_n[*2])
      else $error("management pulse too short");
   a_throttle_min: assert property (
      $rose(thermal_throttle_n) |-> thr_cnt_ff >= THR_CYC)
      else $error("throttle released too early");
   a_trip_power_off: assert property (
      $fell(thermal_shutdown_n) |-> ##[1:4] !supply_ok_in)
      else $error("supply not removed after shutdown");
   a_tck_period: assert property (
      $rose(tck) |-> tck[*8] ##1 !tck[*7])
      else $error("test clock period too short");
   a_trst_width: assert property (
      $fell(trst_n) |-> !trst_n throughout (##[1:40] $rose(tck) ##[1:40] $rose(tck)))
      else $error("test reset too short");
   a_trst_tms: assert property (
      $rose(trst_n) |-> tms)
      else $error("mode low at test reset release");
endmodule

// file: tb.sv
// Self-checking bench joining the processor end and the platform end
`timescale 1ns/1ps
module tb;
   import crcs_pkg::*;
   localparam int          RST_CYC = 20;
   localparam int          THR_CYC = 16;
   localparam logic [31:0] PAT     = 32'hc3a5_1e96;
   logic mclk = 1'h0, resetn = 1'h0, power_req = 1'h0, init_req = 1'h0, mgmt_req = 1'h0;
   logic strap_breq = 1'h0, strap_init = 1'h0, strap_mgmt = 1'h0, temp_hot = 1'h0;
   logic tap_rst_req = 1'h0, tap_shift_req = 1'h0, tap_tms_in = 1'h0, tap_tdi_in = 1'h0;
   logic temp_trip = 1'h0, insn_busy = 1'h0, core_rst_n, cfg_valid, init_evt, mgmt_evt;
   logic clk_mod_on, vcore_en, sys_ready, tripped, hot_seen, tap_busy, tap_done, tap_tdo;
   logic [CFG_ADDR_W-1:0] strap_addr = '0;
   logic [CFG_W-1:0]      cfg_word;
   logic [63:0]           tdo_bits;
   int                    num_errors = 0, comparisons = 0, cyc = 0;
   crcs_if link();
   crcs_dev #(.THROT_CYC(THR_CYC)) u_crcs_dev (.mclk(mclk), .resetn(resetn), .pins(link.dev),
      .core_rst_n(core_rst_n), .cfg_valid(cfg_valid), .cfg_word(cfg_word), .init_evt(init_evt),
      .mgmt_evt(mgmt_evt), .temp_hot(temp_hot), .temp_trip(temp_trip), .insn_busy(insn_busy),
      .clk_mod_on(clk_mod_on));
   crcs_plat #(.RST_CYC(RST_CYC)) u_crcs_plat (.mclk(mclk), .resetn(resetn), .pins(link.plat),
      .power_req(power_req), .vcore_en(vcore_en), .sys_ready(sys_ready), .tripped(tripped),
      .hot_seen(hot_seen), .strap_addr(strap_addr), .strap_breq(strap_breq),
      .strap_init(strap_init), .strap_mgmt(strap_mgmt), .init_req(init_req),
      .mgmt_req(mgmt_req), .tap_rst_req(tap_rst_req), .tap_shift_req(tap_shift_req),
      .tap_tms_in(tap_tms_in), .tap_tdi_in(tap_tdi_in), .tap_busy(tap_busy),
      .tap_done(tap_done), .tap_tdo(tap_tdo));
   crcs_checker #(.RST_CYC(RST_CYC), .THR_CYC(THR_CYC)) u_crcs_checker (.mclk(mclk),
      .resetn(resetn), .supply_ok_in(link.supply_ok_in), .reset_n(link.reset_n),
      .cfg_addr_n(link.cfg_addr_n), .bus_request0_n(link.bus_request0_n),
      .soft_init_n(link.soft_init_n), .mgmt_interrupt_n(link.mgmt_interrupt_n),
      .thermal_throttle_n(link.thermal_throttle_n), .tms(link.tms), .trst_n(link.trst_n),
      .thermal_shutdown_n(link.thermal_shutdown_n), .tck(link.tck));
   // Clock and cycle count
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic await(ref logic s, input logic v, input string what);
      for (int i = 0; i < 200 && s !== v; i++) @(posedge mclk);
      check(what, 64'(v), 64'(s));
   endtask
   task automatic t_power_up(input logic [CFG_W-1:0] s);
      int n;
      n = 0;
      {strap_addr, strap_breq, strap_init, strap_mgmt} <= s;
      power_req <= 1'h1;
      await(link.supply_ok_in, 1'h1, "supply_ok_in");
      while (!link.reset_n && n < 300) begin
         n++;
         @(posedge mclk);
      end
      check("reset wait", 64'(RST_CYC), 64'(n));
      await(cfg_valid, 1'h1, "cfg_valid");
      check("cfg_word", 64'(s), 64'(cfg_word));
      check("core_rst_n", 64'h1, 64'(core_rst_n));
      await(sys_ready, 1'h1, "sys_ready");
      {strap_addr, strap_breq, strap_init, strap_mgmt} <= ~s;
      repeat (6) @(posedge mclk);
      check("cfg_word kept", 64'(s), 64'(cfg_word));
   endtask
   task automatic t_sideband();
      init_req <= 1'h1;
      mgmt_req <= 1'h1;
      @(posedge mclk);
      init_req <= 1'h0;
      mgmt_req <= 1'h0;
      await(init_evt, 1'h1, "init_evt");
      check("mgmt_evt", 64'h1, 64'(mgmt_evt));
      @(posedge mclk);
      check("init_evt end", 64'h0, 64'(init_evt));
   endtask
   task automatic t_throttle();
      int t0;
      temp_hot <= 1'h1;
      insn_busy <= 1'h1;
      await(link.thermal_throttle_n, 1'h0, "throttle on");
      t0 = cyc;
      repeat (3) @(posedge mclk);
      check("mod during busy", 64'h0, 64'(clk_mod_on));
      insn_busy <= 1'h0;
      await(clk_mod_on, 1'h1, "clk_mod_on");
      check("hot_seen", 64'h1, 64'(hot_seen));
      temp_hot <= 1'h0;
      insn_busy <= 1'h1;
      await(clk_mod_on, 1'h0, "mod off");
      repeat (3) @(posedge mclk);
      check("throttle busy", 64'h0, 64'(link.thermal_throttle_n));
      insn_busy <= 1'h0;
      await(link.thermal_throttle_n, 1'h1, "throttle off");
      check("throttle length", 64'h1, 64'(cyc - t0 >= THR_CYC));
   endtask
   task automatic t_tap();
      tap_rst_req <= 1'h1;
      @(posedge mclk);
      tap_rst_req <= 1'h0;
      @(posedge mclk);
      check("tap_busy", 64'h1, 64'(tap_busy));
      await(tap_done, 1'h1, "tap reset");
      for (int i = 0; i < 64; i++) begin
         tap_shift_req <= 1'h1;
         tap_tms_in <= 1'h0;
         tap_tdi_in <= PAT[i % 32];
         @(posedge mclk);
         tap_shift_req <= 1'h0;
         await(tap_done, 1'h1, "tap shift");
         tdo_bits[i] = tap_tdo;
      end
      check("tdo chain", {PAT, TAP_IDENT}, tdo_bits);
   endtask
   task automatic t_abort();
      int n;
      n = 0;
      power_req <= 1'h0;
      await(link.supply_ok_in, 1'h0, "supply drop");
      power_req <= 1'h1;
      while (!link.supply_ok_in && n < 100) begin
         n++;
         @(posedge mclk);
      end
      check("power-good off", 64'h1, 64'(n >= 10));
      t_power_up('1);
   endtask
   task automatic t_trip();
      temp_trip <= 1'h1;
      await(link.thermal_shutdown_n, 1'h0, "shutdown");
      await(tripped, 1'h1, "tripped");
      check("vcore_en", 64'h0, 64'(vcore_en));
      temp_trip <= 1'h0;
      power_req <= 1'h0;
      resetn <= 1'h0;
      repeat (5) @(posedge mclk);
      resetn <= 1'h1;
      @(posedge mclk);
      check("shutdown cleared", 64'h1, 64'(link.thermal_shutdown_n));
   endtask
   task automatic summarize();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'h1;
      @(posedge mclk);
      t_power_up(32'h5a5a_c3a6);
      t_sideband();
      t_throttle();
      t_tap();
      t_abort();
      t_trip();
      t_power_up(32'h0000_0001);
      summarize();
   end
endmodule
